// [dv/ccs_inst_model.sv]
// Instrument-side model: background work, self test runner, trigger counter.
// Assumes the unit's hclk and its active-low asynchronous reset.
`timescale 1ns/1ps
module ccs_inst_model #(
  parameter logic [7:0] TST_CODE = 8'h3c,
  parameter int TST_LAT = 12
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bench control
  input wire logic work_go,
  input wire logic [7:0] work_len,
  // Unit side
  input wire logic tst_start,
  input wire logic trg_pulse,
  output logic op_pending,
  output logic tst_done,
  output logic [7:0] tst_code,
  output logic [7:0] trg_count
);
  logic [7:0] work_reg;
  logic [7:0] tst_reg;
  assign op_pending = (work_reg != 8'h00);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      work_reg <= 8'h00;
      tst_reg <= 8'h00;
      tst_done <= 1'b0;
      tst_code <= 8'h00;
      trg_count <= 8'h00;
    end else begin
      work_reg <= work_go ? work_len : work_reg - {7'h00, op_pending};
      tst_reg <= tst_start ? 8'(TST_LAT) : tst_reg - {7'h00, tst_reg != 8'h00};
      tst_done <= (tst_reg == 8'h01);
      // Code is only meaningful with done; toggle otherwise so stale reads show
      tst_code <= (tst_reg == 8'h01) ? TST_CODE : ~tst_code;
      trg_count <= trg_count + {7'h00, trg_pulse};
    end
  end
endmodule

// [dv/ccs_unit_tb_top.sv]
// Self-checking bench for the common command and status unit.
// Assumes the unit answers every AHB-Lite transfer with OKAY.
`timescale 1ns/1ps
module ccs_unit_tb_top;
  import ccs_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] v;} ccs_exp_t;
  localparam logic [31:0] PRESET = 32'h0f0f_0001;
  localparam logic [7:0] TCODE = 8'h3c;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic pon_pin = 1'b0;
  logic work_go = 1'b0;
  logic [7:0] work_len = 8'h28;
  logic [14:0] opts = 15'h0000;
  logic [15:0] ques_in = 16'h0000;
  logic hreadyout, hresp, trg_pulse, tst_start, srq, ist, busy, op_pending, tst_done;
  logic [31:0] hrdata, inst_state, rd, s1, s2, rnd;
  logic [7:0] tst_code, trg_count;
  logic rd_ph = 1'b0;
  ccs_exp_t exp_q[$];
  ccs_exp_t e;
  int n_errors = 0;
  int cmp_count = 0;

  always #5 hclk = ~hclk;

  ccs_unit #(.PRESET_STATE(PRESET)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .opt_installed(opts), .op_pending(op_pending), .tst_done(tst_done),
    .tst_code(tst_code), .inst_state(inst_state), .trg_pulse(trg_pulse),
    .tst_start(tst_start), .pon_pin(pon_pin), .ques_pin(ques_in), .oper_pin(16'h0000),
    .srq(srq), .ist(ist), .busy(busy));

  ccs_inst_model #(.TST_CODE(TCODE)) model (.hclk(hclk), .hresetn(hresetn),
    .work_go(work_go), .work_len(work_len), .tst_start(tst_start), .trg_pulse(trg_pulse),
    .op_pending(op_pending), .tst_done(tst_done), .tst_code(tst_code),
    .trg_count(trg_count));

  task automatic cmp_word(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] g);
    cmp_count++;
    if (g !== ev) begin
      n_errors++;
      $display("ERROR read at offset %h expected %h seen %h", a, ev, g);
    end
  endtask

  task automatic cmp_sig(input string n, input logic [31:0] ev, input logic [31:0] g);
    cmp_count++;
    if (g !== ev) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, ev, g);
    end
  endtask

  // Status polls of CTRL are not results; every other read takes a note
  always @(posedge hclk) begin
    if (rd_ph && hreadyout === 1'b1 && exp_q.size() != 0) begin
      e = exp_q.pop_front();
      cmp_word(e.a, e.v, hrdata);
    end
    if (hreadyout === 1'b1) begin
      rd_ph <= hsel && htrans[1] && !hwrite && (haddr[7:0] != CCS_A_CTRL);
    end
  end

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rv);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, rd);
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] v);
    exp_q.push_back({a, v});
    ahb(1'b0, a, 32'h0000_0000, rd);
  endtask

  task automatic cmd(input logic [23:0] h, input logic [7:0] x, input logic q,
                     input logic p, input logic [15:0] prm);
    logic [31:0] r;
    wr(CCS_A_HDR, {CCS_ASC_STAR, h});
    wr(CCS_A_EXT, {24'h00_0000, x});
    wr(CCS_A_CTRL, {1'b1, 5'h00, q, p, 8'($urandom), prm});
    r = 32'h0000_0001;
    while (r[0] !== 1'b0) ahb(1'b0, CCS_A_CTRL, 32'h0000_0000, r);
  endtask

  task automatic qry(input logic [23:0] h, input logic [7:0] x, input logic q,
                     input logic [31:0] ev);
    cmd(h, x, q, 1'b0, 16'h0000);
    chk(CCS_A_RESP, ev);
  endtask

  task automatic pon();
    pon_pin <= 1'b1;
    repeat (6) @(posedge hclk);
    pon_pin <= 1'b0;
    repeat (4) @(posedge hclk);
  endtask

  task automatic work();
    work_go <= 1'b1;
    @(posedge hclk);
    work_go <= 1'b0;
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Whole sequence needs under a thousand cycles; over thirty times that means a hang
  initial begin
    repeat (30000) @(posedge hclk);
    n_errors++;
    $display("ERROR watchdog expected finish seen hang");
    final_report();
  end

  initial begin
    void'($urandom(99));
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    qry(24'h45_5352, CCS_ASC_NUL, 1'b1, 32'h0000_0080);
    qry(24'h45_5352, CCS_ASC_NUL, 1'b1, 32'h0000_0000);
    $display("test event read-clear done");
    cmd(24'h45_5345, CCS_ASC_SPACE, 1'b0, 1'b1, 16'h00a5);
    qry(24'h45_5345, CCS_ASC_QMARK, 1'b0, 32'h0000_00a5);
    qry(24'h65_7365, CCS_ASC_NUL, 1'b1, 32'h0000_00a5);
    cmd(24'h45_5345, CCS_ASC_NUL, 1'b0, 1'b1, 16'h0100);
    qry(24'h45_5345, CCS_ASC_NUL, 1'b1, 32'h0000_00a5);
    cmd(24'h45_3145, CCS_ASC_NUL, 1'b0, 1'b0, 16'h0000);
    qry(24'h45_5352, CCS_ASC_NUL, 1'b1, 32'(1 << CCS_ESR_EXE) | 32'(1 << CCS_ESR_CME));
    $display("test event enable done");
    cmd(24'h53_5245, CCS_ASC_NUL, 1'b0, 1'b1, 16'h00ff);
    qry(24'h53_5245, CCS_ASC_NUL, 1'b1, 32'h0000_00bf);
    rnd = $urandom;
    cmd(24'h50_5245, CCS_ASC_NUL, 1'b0, 1'b1, {8'h00, rnd[7:0]});
    qry(24'h50_5245, CCS_ASC_NUL, 1'b1, {24'h00_0000, rnd[7:0]});
    $display("test service and poll enables done");
    s1 = $urandom;
    s2 = ~s1;
    wr(CCS_A_STATE, s1);
    cmd(24'h53_4156, CCS_ASC_NUL, 1'b0, 1'b1, 16'h0032);
    wr(CCS_A_STATE, s2);
    chk(CCS_A_STATE, s2);
    cmd(24'h52_434c, CCS_ASC_NUL, 1'b0, 1'b1, 16'h0032);
    chk(CCS_A_STATE, s1);
    cmd(24'h53_4156, CCS_ASC_NUL, 1'b0, 1'b1, 16'h0000);
    cmd(24'h52_434c, CCS_ASC_NUL, 1'b0, 1'b1, 16'h0033);
    chk(CCS_A_STATE, s1);
    qry(24'h45_5352, CCS_ASC_NUL, 1'b1, 32'(1 << CCS_ESR_EXE));
    cmd(24'h52_434c, CCS_ASC_NUL, 1'b0, 1'b1, 16'h0000);
    chk(CCS_A_STATE, PRESET);
    wr(CCS_A_STATE, s2);
    cmd(24'h52_5354, CCS_ASC_NUL, 1'b0, 1'b0, 16'h0000);
    chk(CCS_A_STATE, PRESET & 32'hffff_fffe);
    cmp_sig("inst_state", PRESET & 32'hffff_fffe, inst_state);
    $display("test save recall reset done");
    qry(24'h49_444e, CCS_ASC_NUL, 1'b1, 32'h5a01_0110);
    opts <= 15'($urandom);
    @(posedge hclk);
    qry(24'h4f_5054, CCS_ASC_NUL, 1'b1, {17'h0_0000, opts});
    qry(24'h54_5354, CCS_ASC_NUL, 1'b1, {24'h00_0000, TCODE});
    cmd(24'h54_5247, CCS_ASC_NUL, 1'b0, 1'b0, 16'h0000);
    cmp_sig("trg_count", 32'h0000_0001, {24'h00_0000, trg_count});
    $display("test identity self test trigger done");
    work();
    cmd(24'h4f_5043, CCS_ASC_NUL, 1'b0, 1'b0, 16'h0000);
    cmp_sig("op_pending", 32'h0000_0000, {31'h0, op_pending});
    qry(24'h45_5352, CCS_ASC_NUL, 1'b1, 32'(1 << CCS_ESR_OPC));
    work();
    cmd(24'h57_4149, CCS_ASC_NUL, 1'b0, 1'b0, 16'h0000);
    cmp_sig("op_pending", 32'h0000_0000, {31'h0, op_pending});
    cmp_sig("busy", 32'h0000_0000, {31'h0, busy});
    $display("test completion and wait done");
    ques_in <= 16'h0004;
    repeat (4) @(posedge hclk);
    chk(CCS_A_QUES, 32'h0000_0004);
    cmd(24'h45_5345, CCS_ASC_NUL, 1'b0, 1'b1, 16'h012c);
    cmd(24'h43_4c53, CCS_ASC_NUL, 1'b0, 1'b0, 16'h0000);
    chk(CCS_A_QUES, 32'h0000_0000);
    chk(CCS_A_STAT, {8'h00, rnd[7:0], 16'h0000});
    qry(24'h45_5345, CCS_ASC_NUL, 1'b1, 32'h0000_00a5);
    // Unread answer leaves MAV set, so the status byte is MAV plus MSS
    cmd(24'h49_444e, CCS_ASC_NUL, 1'b1, 1'b0, 16'h0000);
    qry(24'h53_5442, CCS_ASC_NUL, 1'b1, 32'h0000_0050);
    cmd(24'h49_444e, CCS_ASC_NUL, 1'b1, 1'b0, 16'h0000);
    cmp_sig("ist", {31'h0, |(rnd[7:0] & 8'h50)}, {31'h0, ist});
    qry(24'h49_5354, CCS_ASC_NUL, 1'b1, {31'h0, |(rnd[7:0] & 8'h50)});
    cmp_sig("hresp", 32'h0000_0000, {31'h0, hresp});
    $display("test clear status done");
    cmd(24'h50_5343, CCS_ASC_NUL, 1'b0, 1'b1, 16'h0000);
    pon();
    cmp_sig("srq", 32'h0000_0001, {31'h0, srq});
    qry(24'h45_5345, CCS_ASC_NUL, 1'b1, 32'h0000_00a5);
    qry(24'h50_5343, CCS_ASC_NUL, 1'b1, 32'h0000_0000);
    cmd(24'h50_5343, CCS_ASC_NUL, 1'b0, 1'b1, 16'h0007);
    qry(24'h50_5343, CCS_ASC_NUL, 1'b1, 32'h0000_0001);
    pon();
    qry(24'h45_5345, CCS_ASC_NUL, 1'b1, 32'h0000_0000);
    qry(24'h53_5245, CCS_ASC_NUL, 1'b1, 32'h0000_0000);
    $display("test power-on clear done");
    final_report();
  end
endmodule

// [verilog/ccs_pkg.sv]
// Package for the common command and status unit: offsets, bit positions,
// reset values, command codes and carrier types.
// Assumes an AHB-Lite master with 32-bit single word transfers.
package ccs_pkg;
  // Register byte offsets
  localparam logic [7:0] CCS_A_CTRL = 8'h00;
  localparam logic [7:0] CCS_A_HDR = 8'h04;
  localparam logic [7:0] CCS_A_EXT = 8'h08;
  localparam logic [7:0] CCS_A_RESP = 8'h0c;
  localparam logic [7:0] CCS_A_STATE = 8'h10;
  localparam logic [7:0] CCS_A_STAT = 8'h14;
  localparam logic [7:0] CCS_A_QUES = 8'h18;
  localparam logic [7:0] CCS_A_OPER = 8'h1c;
  // Standard event register bits
  localparam int CCS_ESR_OPC = 0;
  localparam int CCS_ESR_EXE = 4;
  localparam int CCS_ESR_CME = 5;
  localparam int CCS_ESR_PON = 7;
  // Status byte bits
  localparam int CCS_STB_QUES = 3;
  localparam int CCS_STB_MAV = 4;
  localparam int CCS_STB_ESB = 5;
  localparam int CCS_STB_MSS = 6;
  localparam int CCS_STB_OPER = 7;
  // Parameter limits
  localparam logic [15:0] CCS_MAX_BYTE = 16'h00ff;
  localparam logic [15:0] CCS_MAX_SLOT = 16'h0032;
  localparam logic [15:0] CCS_MIN_SAV = 16'h0001;
  // Header characters
  localparam logic [7:0] CCS_ASC_STAR = 8'h2a;
  localparam logic [7:0] CCS_ASC_QMARK = 8'h3f;
  localparam logic [7:0] CCS_ASC_SPACE = 8'h20;
  localparam logic [7:0] CCS_ASC_NUL = 8'h00;
  localparam logic [7:0] CCS_ASC_LA = 8'h61;
  localparam logic [7:0] CCS_ASC_LZ = 8'h7a;
  localparam logic [7:0] CCS_ASC_UA = 8'h41;
  localparam logic [7:0] CCS_ASC_UZ = 8'h5a;
  localparam logic [7:0] CCS_ASC_CASE = 8'h20;
  // Reset values
  localparam logic [7:0] CCS_ESR_RST = 8'h80;
  localparam logic CCS_PSC_RST = 1'b1;
  localparam int CCS_RF_BIT = 0;

  typedef enum logic [2:0] {
    CCS_S_IDLE = 3'b000,
    CCS_S_EXEC = 3'b001,
    CCS_S_OPC = 3'b010,
    CCS_S_WAI = 3'b011,
    CCS_S_TST = 3'b100
  } ccs_state_t;

  typedef enum logic [4:0] {
    CCS_C_BAD = 5'b00000, CCS_C_CLS = 5'b00001, CCS_C_ESE = 5'b00010,
    CCS_C_ESR = 5'b00011, CCS_C_IDN = 5'b00100, CCS_C_IST = 5'b00101,
    CCS_C_OPC = 5'b00110, CCS_C_OPT = 5'b00111, CCS_C_PCB = 5'b01000,
    CCS_C_PRE = 5'b01001, CCS_C_PSC = 5'b01010, CCS_C_RCL = 5'b01011,
    CCS_C_RST = 5'b01100, CCS_C_SAV = 5'b01101, CCS_C_SRE = 5'b01110,
    CCS_C_STB = 5'b01111, CCS_C_TRG = 5'b10000, CCS_C_TST = 5'b10001,
    CCS_C_WAI = 5'b10010
  } ccs_cmd_t;

  // Command control word as written to CTRL
  typedef struct packed {
    logic go;
    logic [4:0] rsv;
    logic query;
    logic present;
    logic [7:0] group_cnt;
    logic [15:0] param;
  } ccs_ctrl_t;
endpackage

// [verilog/ccs_unit.sv]
// Common command and status unit: header decode, status byte, event and
// enable registers, save/recall store, trigger, self test, OPC and WAI.
// Assumes a single AHB-Lite master on hclk; instrument handshakes are on hclk,
// event and power-on pins are asynchronous.
//
// Our own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
// Contract
// - Header letters compare without regard to case.
// - Alternative query marks, flag bit or question mark, behave identically.
// - Optional trailing character and optional parameters may be present or absent.
// - Any repeat count of a parameter group is accepted.
// - A common header is an asterisk and exactly three letters.
// - Clear status zeroes status, event registers, output buffer; keeps masks.
// - Event enable loads 0 to 255; query returns it.
// - Event register query returns 0 to 255 then clears it.
// - Individual status query returns the parallel poll bit, 0 or 1.
// - Operation complete sets event bit 0 once earlier work finishes.
// - Option query gives 15 fixed positions, zero when absent.
// - Parallel poll enable loads 0 to 255; query returns it.
// - Power-on clear 0 keeps enables at power-up; nonzero clears them.
// - Recall restores stored state 0 to 50; 50 storable states.
// - Save stores current state under 1 to 50.
// - Reset loads the preset state with the RF output off.
// - Service request enable loads 0 to 255 with bit 6 zero.
// - Status byte query returns the current status byte.
// - Trigger fires every action waiting for a trigger.
// - Self test query runs the tests and returns the error code.
// - Wait holds later commands until earlier ones complete.
// - Identification returns maker, variant, serial and firmware fields.
module ccs_unit #(
  parameter int SW = 32,
  parameter int NSLOT = 50,
  parameter logic [SW-1:0] PRESET_STATE = '0,
  parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] VARIANT_ID = 8'h01, // Arbitrary value
  parameter logic [7:0] SERIAL_ID = 8'h01, // Arbitrary value
  parameter logic [7:0] FW_ID = 8'h10 // Arbitrary value
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Instrument side, same clock
  input wire logic [14:0] opt_installed,
  input wire logic op_pending,
  input wire logic tst_done,
  input wire logic [7:0] tst_code,
  output logic [SW-1:0] inst_state,
  output logic trg_pulse,
  output logic tst_start,
  // Asynchronous pins
  input wire logic pon_pin,
  input wire logic [15:0] ques_pin,
  input wire logic [15:0] oper_pin,
  // Status outputs
  output logic srq,
  output logic ist,
  output logic busy
);
  import ccs_pkg::*;

  function automatic logic [7:0] up(input logic [7:0] c);
    up = (c >= CCS_ASC_LA && c <= CCS_ASC_LZ) ? (c ^ CCS_ASC_CASE) : c;
  endfunction

  function automatic logic letter(input logic [7:0] c);
    letter = up(c) >= CCS_ASC_UA && up(c) <= CCS_ASC_UZ;
  endfunction

  function automatic ccs_cmd_t decode(input logic [31:0] h, input logic [7:0] e);
    logic [23:0] k;
    k = {up(h[23:16]), up(h[15:8]), up(h[7:0])};
    decode = CCS_C_BAD;
    if (h[31:24] == CCS_ASC_STAR && letter(h[23:16]) && letter(h[15:8]) && letter(h[7:0])
        && (e == CCS_ASC_NUL || e == CCS_ASC_SPACE || e == CCS_ASC_QMARK)) begin
      case (k)
        24'h43_4c53: decode = CCS_C_CLS;
        24'h45_5345: decode = CCS_C_ESE;
        24'h45_5352: decode = CCS_C_ESR;
        24'h49_444e: decode = CCS_C_IDN;
        24'h49_5354: decode = CCS_C_IST;
        24'h4f_5043: decode = CCS_C_OPC;
        24'h4f_5054: decode = CCS_C_OPT;
        24'h50_4342: decode = CCS_C_PCB;
        24'h50_5245: decode = CCS_C_PRE;
        24'h50_5343: decode = CCS_C_PSC;
        24'h52_434c: decode = CCS_C_RCL;
        24'h52_5354: decode = CCS_C_RST;
        24'h53_4156: decode = CCS_C_SAV;
        24'h53_5245: decode = CCS_C_SRE;
        24'h53_5442: decode = CCS_C_STB;
        24'h54_5247: decode = CCS_C_TRG;
        24'h54_5354: decode = CCS_C_TST;
        24'h57_4149: decode = CCS_C_WAI;
        default: decode = CCS_C_BAD;
      endcase
    end
  endfunction

  ccs_state_t state_reg, state_next;
  ccs_ctrl_t ctrl_reg;
  logic [31:0] hdr_reg;
  logic [7:0] ext_reg;
  logic [7:0] ese_reg, sre_reg, pre_reg, esr_reg;
  logic psc_reg;
  logic [15:0] ques_reg, oper_reg;
  logic [31:0] resp_reg;
  logic resp_valid_reg;
  logic [SW-1:0] state_cur_reg;
  logic wr_pend_reg;
  logic [7:0] waddr_reg;
  logic [31:0] hrdata_reg;
  logic [SW-1:0] slot_mem [1:NSLOT];

  // Two-flop synchronisers, third stage only for edge detection
  logic pon_s1, pon_s2, pon_s3;
  logic [15:0] ques_s1, ques_s2, ques_s3, oper_s1, oper_s2, oper_s3;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {pon_s1, pon_s2, pon_s3} <= 3'b000;
      {ques_s1, ques_s2, ques_s3} <= '0;
      {oper_s1, oper_s2, oper_s3} <= '0;
    end else begin
      {pon_s3, pon_s2, pon_s1} <= {pon_s2, pon_s1, pon_pin};
      {ques_s3, ques_s2, ques_s1} <= {ques_s2, ques_s1, ques_pin};
      {oper_s3, oper_s2, oper_s1} <= {oper_s2, oper_s1, oper_pin};
    end
  end
  wire pon_evt = pon_s2 & ~pon_s3;
  wire [15:0] ques_set = ques_s2 & ~ques_s3;
  wire [15:0] oper_set = oper_s2 & ~oper_s3;

  // AHB-Lite: zero wait states, always OKAY
  wire bus_acc = hsel & htrans[1] & hready;
  wire bus_rd = bus_acc & ~hwrite;
  wire [7:0] raddr = haddr[7:0];
  wire wr_en = wr_pend_reg;
  wire wr_ctrl = wr_en && waddr_reg == CCS_A_CTRL;
  wire wr_hdr = wr_en && waddr_reg == CCS_A_HDR;
  wire wr_ext = wr_en && waddr_reg == CCS_A_EXT;
  wire wr_state = wr_en && waddr_reg == CCS_A_STATE;
  wire rd_resp = bus_rd && raddr == CCS_A_RESP;
  // Commands written while busy are dropped; software polls busy first
  wire go = wr_ctrl && hwdata[31] && state_reg == CCS_S_IDLE;

  // Status byte and poll bit
  wire esb = |(esr_reg & ese_reg);
  wire [7:0] stb_low = {|oper_reg, 1'b0, esb, resp_valid_reg, |ques_reg, 3'b000};
  wire mss = |(stb_low & sre_reg);
  wire [7:0] stb = stb_low | ({7'b0, mss} << CCS_STB_MSS);
  wire ist_w = |(stb & pre_reg);

  wire [31:0] stat_word = {8'h00, pre_reg, esr_reg, stb};
  wire [31:0] ctrl_rd = {28'h000_0000, psc_reg, 2'b00, state_reg != CCS_S_IDLE};
  wire [31:0] rd_mux =
    raddr == CCS_A_CTRL ? ctrl_rd :
    raddr == CCS_A_HDR ? hdr_reg :
    raddr == CCS_A_EXT ? {24'h00_0000, ext_reg} :
    raddr == CCS_A_RESP ? resp_reg :
    raddr == CCS_A_STATE ? 32'(state_cur_reg) :
    raddr == CCS_A_STAT ? stat_word :
    raddr == CCS_A_QUES ? {16'h0000, ques_reg} :
    raddr == CCS_A_OPER ? {16'h0000, oper_reg} : 32'h0000_0000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      waddr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= bus_acc & hwrite;
      if (bus_acc) waddr_reg <= raddr;
      if (bus_rd) hrdata_reg <= rd_mux;
    end
  end

  // Command decode of the latched header
  wire ccs_cmd_t cmd = decode(hdr_reg, ext_reg);
  wire qry = ctrl_reg.query | (ext_reg == CCS_ASC_QMARK);
  wire has_p = ctrl_reg.present; // group count is accepted whatever it is
  wire [15:0] par = ctrl_reg.param;
  wire byte_ok = par <= CCS_MAX_BYTE;
  wire rcl_ok = par <= CCS_MAX_SLOT;
  wire sav_ok = par >= CCS_MIN_SAV && par <= CCS_MAX_SLOT;
  wire exec = state_reg == CCS_S_EXEC;

  logic ese_ld, sre_ld, pre_ld, psc_ld, esr_clr, cls, cme, exe, opc_set;
  logic rst_do, rcl_do, sav_do, trg_do, tst_go, resp_ld;
  logic [31:0] resp_val;
  always_comb begin
    {ese_ld, sre_ld, pre_ld, psc_ld, esr_clr, cls, cme, exe, opc_set} = '0;
    {rst_do, rcl_do, sav_do, trg_do, tst_go, resp_ld} = '0;
    resp_val = 32'h0000_0000;
    state_next = state_reg;
    case (state_reg)
      CCS_S_IDLE: begin
        if (go) state_next = CCS_S_EXEC;
      end
      CCS_S_EXEC: begin
        state_next = CCS_S_IDLE;
        case (cmd)
          CCS_C_CLS: if (qry) cme = 1'b1; else cls = 1'b1;
          CCS_C_ESE, CCS_C_SRE, CCS_C_PRE: begin
            resp_val = {24'h00_0000, cmd == CCS_C_ESE ? ese_reg :
                        cmd == CCS_C_SRE ? sre_reg : pre_reg};
            if (qry) resp_ld = 1'b1;
            else if (!has_p) cme = 1'b1;
            else if (!byte_ok) exe = 1'b1;
            else begin
              ese_ld = cmd == CCS_C_ESE;
              sre_ld = cmd == CCS_C_SRE;
              pre_ld = cmd == CCS_C_PRE;
            end
          end
          CCS_C_PSC: begin
            resp_val = {31'h0000_0000, psc_reg};
            if (qry) resp_ld = 1'b1;
            else if (!has_p) cme = 1'b1;
            else psc_ld = 1'b1;
          end
          CCS_C_ESR, CCS_C_STB, CCS_C_IST, CCS_C_IDN, CCS_C_OPT: begin
            resp_val = cmd == CCS_C_ESR ? {24'h00_0000, esr_reg} :
                       cmd == CCS_C_STB ? {24'h00_0000, stb} :
                       cmd == CCS_C_IST ? {31'h0000_0000, ist_w} :
                       cmd == CCS_C_IDN ? {MAKER_ID, VARIANT_ID, SERIAL_ID, FW_ID} :
                       {17'h0_0000, opt_installed};
            if (!qry) cme = 1'b1;
            else begin
              resp_ld = 1'b1;
              esr_clr = cmd == CCS_C_ESR;
            end
          end
          CCS_C_RCL: begin
            if (qry || !has_p) cme = 1'b1;
            else if (!rcl_ok) exe = 1'b1;
            else rcl_do = 1'b1;
          end
          CCS_C_SAV: begin
            if (qry || !has_p) cme = 1'b1;
            else if (!sav_ok) exe = 1'b1;
            else sav_do = 1'b1;
          end
          CCS_C_RST: if (qry) cme = 1'b1; else rst_do = 1'b1;
          CCS_C_TRG: if (qry) cme = 1'b1; else trg_do = 1'b1;
          CCS_C_TST: begin
            if (!qry) cme = 1'b1;
            else begin
              tst_go = 1'b1;
              state_next = CCS_S_TST;
            end
          end
          CCS_C_OPC: state_next = CCS_S_OPC;
          CCS_C_WAI: if (qry) cme = 1'b1; else state_next = CCS_S_WAI;
          CCS_C_PCB: cme = qry;
          default: cme = 1'b1;
        endcase
      end
      CCS_S_OPC: begin
        if (!op_pending) begin
          state_next = CCS_S_IDLE;
          resp_val = 32'h0000_0001;
          resp_ld = qry;
          opc_set = ~qry;
        end
      end
      CCS_S_WAI: if (!op_pending) state_next = CCS_S_IDLE;
      CCS_S_TST: begin
        if (tst_done) begin
          state_next = CCS_S_IDLE;
          resp_val = {24'h00_0000, tst_code};
          resp_ld = 1'b1;
        end
      end
      default: state_next = CCS_S_IDLE;
    endcase
  end

  // Event bits: a set in the same cycle as a clear wins
  wire [7:0] esr_set = ({7'b0, opc_set} << CCS_ESR_OPC) | ({7'b0, exe} << CCS_ESR_EXE)
                     | ({7'b0, cme} << CCS_ESR_CME) | ({7'b0, pon_evt} << CCS_ESR_PON);
  wire [7:0] esr_next = ((esr_clr | cls) ? 8'h00 : esr_reg) | esr_set;
  wire [15:0] ques_next = (cls ? 16'h0000 : ques_reg) | ques_set;
  wire [15:0] oper_next = (cls ? 16'h0000 : oper_reg) | oper_set;
  wire resp_valid_next = resp_ld | (resp_valid_reg & ~(cls | rd_resp));
  // Power-on event clears enables only when the power-on clear flag is set
  wire en_clr = pon_evt & psc_reg;
  wire [SW-1:0] rcl_val = par == 16'h0000 ? PRESET_STATE : slot_mem[par[5:0]];
  wire [SW-1:0] preset_off = PRESET_STATE & ~(SW'(1) << CCS_RF_BIT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= CCS_S_IDLE;
      ctrl_reg <= '0;
      hdr_reg <= 32'h0000_0000;
      ext_reg <= 8'h00;
      ese_reg <= 8'h00;
      sre_reg <= 8'h00;
      pre_reg <= 8'h00;
      psc_reg <= CCS_PSC_RST;
      esr_reg <= CCS_ESR_RST;
      ques_reg <= 16'h0000;
      oper_reg <= 16'h0000;
      resp_reg <= 32'h0000_0000;
      resp_valid_reg <= 1'b0;
      state_cur_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (go) ctrl_reg <= ccs_ctrl_t'(hwdata);
      if (wr_hdr && state_reg == CCS_S_IDLE) hdr_reg <= hwdata;
      if (wr_ext && state_reg == CCS_S_IDLE) ext_reg <= hwdata[7:0];
      if (en_clr) {ese_reg, sre_reg, pre_reg} <= 24'h00_0000;
      else begin
        if (ese_ld) ese_reg <= par[7:0];
        if (sre_ld) sre_reg <= par[7:0] & ~(8'h01 << CCS_STB_MSS);
        if (pre_ld) pre_reg <= par[7:0];
      end
      if (psc_ld) psc_reg <= par != 16'h0000;
      esr_reg <= esr_next;
      ques_reg <= ques_next;
      oper_reg <= oper_next;
      if (resp_ld) resp_reg <= resp_val;
      resp_valid_reg <= resp_valid_next;
      if (rst_do) state_cur_reg <= preset_off;
      else if (rcl_do) state_cur_reg <= rcl_val;
      else if (wr_state) state_cur_reg <= hwdata[SW-1:0];
    end
  end

  // State store is not reset; recalling a never-saved slot gives stale data
  always_ff @(posedge hclk) begin
    if (sav_do) slot_mem[par[5:0]] <= state_cur_reg;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign inst_state = state_cur_reg;
  assign trg_pulse = trg_do;
  assign tst_start = tst_go;
  assign srq = mss;
  assign ist = ist_w;
  assign busy = state_reg != CCS_S_IDLE;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_ese_load;
    exec && cmd == CCS_C_ESE && !qry && has_p && byte_ok && !en_clr |=> ese_reg == $past(par[7:0]);
  endproperty
  a_ese_load: assert property (p_ese_load) else $error("ese not loaded");

  property p_esr_clear;
    exec && cmd == CCS_C_ESR && qry && !pon_evt |=> esr_reg == 8'h00 && resp_reg == $past({24'h00_0000, esr_reg});
  endproperty
  a_esr_clear: assert property (p_esr_clear) else $error("esr query wrong");

  property p_sre_bit6;
    sre_reg[CCS_STB_MSS] == 1'b0;
  endproperty
  a_sre_bit6: assert property (p_sre_bit6) else $error("sre bit 6 set");

  property p_opc_done;
    state_reg == CCS_S_OPC && !op_pending && !qry |=> esr_reg[CCS_ESR_OPC] && state_reg == CCS_S_IDLE;
  endproperty
  a_opc_done: assert property (p_opc_done) else $error("opc bit not set");

  property p_range;
    exec && (cmd == CCS_C_PRE) && !qry && has_p && !byte_ok && !en_clr
      |=> $stable(pre_reg) && esr_reg[CCS_ESR_EXE];
  endproperty
  a_range: assert property (p_range) else $error("out of range accepted");

  property p_sav_range;
    exec && cmd == CCS_C_SAV && !qry && has_p |-> sav_do == (par >= 16'h0001 && par <= 16'h0032);
  endproperty
  a_sav_range: assert property (p_sav_range) else $error("save range wrong");

  property p_rst_rf;
    exec && cmd == CCS_C_RST && !qry |=> inst_state[CCS_RF_BIT] == 1'b0;
  endproperty
  a_rst_rf: assert property (p_rst_rf) else $error("rf on after reset");

  property p_cls;
    exec && cmd == CCS_C_CLS && !qry && ques_set == 16'h0000 |=> ques_reg == 16'h0000 && !resp_valid_reg;
  endproperty
  a_cls: assert property (p_cls) else $error("clear status incomplete");

  property p_wai_hold;
    state_reg == CCS_S_WAI && op_pending |=> state_reg == CCS_S_WAI;
  endproperty
  a_wai_hold: assert property (p_wai_hold) else $error("wait released early");

  property p_tst_resp;
    state_reg == CCS_S_TST && tst_done |=> resp_valid_reg && resp_reg[7:0] == $past(tst_code);
  endproperty
  a_tst_resp: assert property (p_tst_resp) else $error("self test code lost");

  c_query: cover property (exec && cmd == CCS_C_IDN && qry);
  c_opc: cover property (state_reg == CCS_S_OPC ##[1:20] state_reg == CCS_S_IDLE);
  c_save_recall: cover property (sav_do ##[1:50] rcl_do);
  c_bad: cover property (exec && cmd == CCS_C_BAD);
endmodule
